// ===== cef_map.vh
/*
 * cef_map.vh - register offsets, field positions, reset values and
 * counts for the CAN error-event flags and acceptance mask block.
 * Assumes byte-wide registers on a plain strobe port, 6-bit address.
 */
`ifndef CEF_MAP_VH
`define CEF_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CEF_ADDR_W       6
`define CEF_REG_FLAGS    6'h00
`define CEF_REG_STATE    6'h01
`define CEF_REG_RCVY     6'h02
`define CEF_REG_ACCEPT   6'h03
`define CEF_MB_REGION    1'h1
`define CEF_MB_REGION_B  5

// ----------------------------------------------------------------
// per-mailbox register slots (address bits 2:0)
// ----------------------------------------------------------------
`define CEF_MB_MASK_H1   3'h0
`define CEF_MB_MASK_H0   3'h1
`define CEF_MB_MASK_L0   3'h2
`define CEF_MB_MASK_L1   3'h3
`define CEF_MB_ID_STDH   3'h4
`define CEF_MB_ID_STDL   3'h5
`define CEF_MB_ID_EXTM   3'h6
`define CEF_MB_ID_EXTL   3'h7

// ----------------------------------------------------------------
// flag register bit positions and reset value
// ----------------------------------------------------------------
`define CEF_OVL_BIT      7
`define CEF_BOF_BIT      6
`define CEF_EPS_BIT      5
`define CEF_RXW_BIT      4
`define CEF_FLAG_LO      4
`define CEF_FLAGS_RST    4'h0

// ----------------------------------------------------------------
// error counter thresholds and bus-off recovery counts
// ----------------------------------------------------------------
`define CEF_TEC_BUS_OFF  9'h100
`define CEF_TEC_PASSIVE  9'h080
`define CEF_REC_PASSIVE  8'h80
`define CEF_REC_WARN     8'h60
`define CEF_RUN_LEN      4'hb
`define CEF_RCVY_COUNT   8'h80

`endif

// ===== cef_flag_bit.v
/*
 * cef_flag_bit - one sticky event flag, cleared by writing one.
 * Assumes set and clear are single-cycle pulses on clk_in.
 */
`timescale 1ns/100ps

module cef_flag_bit (
	input  wire clk_in,
	input  wire sys_rst_in,
	input  wire set_in,
	input  wire clr_in,
	output wire flag_out
);

	reg flag_q;
	reg flag_d;

	// set beats a clear in the same cycle
	always @* begin
		flag_d = flag_q;
		if (set_in) begin
			flag_d = 1'b1;
		end else if (clr_in) begin
			flag_d = 1'b0;
		end
	end

	// flag register, zero after reset
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_out = flag_q;

endmodule

// ===== cef_id_match.v
/*
 * cef_id_match - acceptance compare of one receive mailbox.
 * Assumes mask and identifier bytes are held stable by the caller.
 */
`timescale 1ns/100ps

module cef_id_match (
	input  wire [7:0]  mask_h1_in,
	input  wire [7:0]  mask_l0_in,
	input  wire [7:0]  mask_l1_in,
	input  wire [7:0]  id_stdh_in,
	input  wire [7:0]  id_stdl_in,
	input  wire [7:0]  id_extm_in,
	input  wire [7:0]  id_extl_in,
	input  wire        rx_ide_in,
	input  wire [10:0] rx_std_id_in,
	input  wire [17:0] rx_ext_id_in,
	output wire        match_out
);

	wire [29:0] mb_id;
	wire [29:0] rx_id;
	wire [29:0] mask_bits;
	wire [29:0] care_ok;

	// mailbox identifier: std 10:0, ide, ext 17:0
	assign mb_id = {id_stdh_in, id_stdl_in[7:5], id_stdl_in[3],
		id_stdl_in[1:0], id_extm_in, id_extl_in};
	assign rx_id = {rx_std_id_in, rx_ide_in, rx_ext_id_in};

	// mask: std 2:0 from high bits 7:5, ext 15:8 and 7:0 from low pair
	assign mask_bits = {8'h00, mask_h1_in[7:5], 1'b0, 2'h0,
		mask_l0_in, mask_l1_in};

	// a zero mask bit demands equality, a one ignores the bit
	// extension bits are ignored for standard frames
	assign care_ok = ~(mb_id ^ rx_id) | mask_bits
		| {12'h000, {18{~rx_ide_in}}};
	assign match_out = &care_ok;

endmodule

// ===== cef_top.v
/*
 * cef_top - CAN error-event flag register and per-mailbox acceptance
 * masks behind a byte-wide strobe port.
 * Assumes error counters, bit timing and frame engine sit outside and
 * deliver counter values and one-cycle event pulses on clk_in.
 */
// Design decisions made here: the register addresses and strobed register access.

// Operation
// - overload frame sent sets its flag
// - bus-off on TEC 256 or recovery
// - bus-off flag marks entry and return
// - TEC or REC at 128 sets passive
// - REC at 96 sets warning flag
// - flags clear only by writing one
// - flags bits 7..4 zero after reset
// - four mailboxes, four masks each
// - mask zero requires identifier bit match
// - mask one ignores identifier bit
// - low masks cover extended bits 15..0
// - high mask bits 7..5 cover std 2..0
// - one independent flag per event source
`timescale 1ns/100ps
`include "cef_map.vh"

module cef_top #(
	parameter NUM_MB = 4
) (
	input  wire                   clk_in,
	input  wire                   sys_rst_in,
	input  wire [`CEF_ADDR_W-1:0] addr_in,
	input  wire [7:0]             wr_data_in,
	input  wire                   wr_strobe_in,
	input  wire                   rd_strobe_in,
	output wire [7:0]             rd_data_out,
	input  wire [8:0]             tec_in,
	input  wire [7:0]             rec_in,
	input  wire                   overload_sent_in,
	input  wire                   bit_tick_in,
	input  wire                   bus_rx_in,
	input  wire                   rx_id_valid_in,
	input  wire                   rx_ide_in,
	input  wire [10:0]            rx_std_id_in,
	input  wire [17:0]            rx_ext_id_in,
	output wire [3:0]             flags_out,
	output wire                   bus_off_out,
	output wire                   error_passive_out,
	output wire                   warning_out,
	output wire                   recovery_done_out,
	output wire [NUM_MB-1:0]      accept_out,
	output wire                   accept_valid_out
);

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------

	// true when the address falls in the mailbox region
	function is_mb_addr;
		input [`CEF_ADDR_W-1:0] a;
		begin
			is_mb_addr = (a[`CEF_MB_REGION_B] == `CEF_MB_REGION);
		end
	endfunction

	// storage index of a mailbox register: mailbox then slot
	function [4:0] mb_index;
		input [`CEF_ADDR_W-1:0] a;
		begin
			mb_index = a[4:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg  [7:0]        mb_mem [0:NUM_MB*8-1];
	reg  [7:0]        rd_data_q;
	reg  [7:0]        rd_data_d;
	reg               tec_off_q;
	reg               passive_q;
	reg               warn_q;
	reg               bus_off_q;
	reg               bus_off_d;
	reg  [3:0]        run_q;
	reg  [3:0]        run_d;
	reg  [7:0]        rcvy_q;
	reg  [7:0]        rcvy_d;
	reg               rcvy_done_q;
	reg  [NUM_MB-1:0] accept_q;
	reg               accept_valid_q;
	reg  [NUM_MB-1:0] last_accept_q;
	wire              tec_off_now;
	wire              passive_now;
	wire              warn_now;
	wire              bus_off_enter;
	wire              bus_off_leave;
	wire              run_done;
	wire              flags_wr;
	wire [3:0]        set_vec;
	wire [3:0]        clr_vec;
	wire [3:0]        flag_vec;
	wire [NUM_MB-1:0] match_vec;
	wire [7:0]        flag_byte;
	wire [7:0]        state_byte;
	wire [7:0]        accept_byte;

	// ----------------------------------------------------------------
	// error counter thresholds
	// ----------------------------------------------------------------

	// comparator levels on the external counters
	assign tec_off_now = (tec_in >= `CEF_TEC_BUS_OFF);
	assign passive_now = (tec_in >= `CEF_TEC_PASSIVE)
		| (rec_in >= `CEF_REC_PASSIVE);
	assign warn_now    = (rec_in >= `CEF_REC_WARN);

	// previous levels, so each flag fires on crossing only
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			tec_off_q <= 1'b0;
			passive_q <= 1'b0;
			warn_q    <= 1'b0;
		end else begin
			tec_off_q <= tec_off_now;
			passive_q <= passive_now;
			warn_q    <= warn_now;
		end
	end

	// ----------------------------------------------------------------
	// bus-off state and recovery counting
	// ----------------------------------------------------------------

	// entry when the transmit counter crosses into bus-off range
	assign bus_off_enter = tec_off_now & ~tec_off_q & ~bus_off_q;

	// eleven recessive bits in a row make one occurrence
	assign run_done = bus_off_q & bit_tick_in & bus_rx_in
		& (run_q == `CEF_RUN_LEN - 4'h1);

	// the last occurrence of the required count ends bus-off
	assign bus_off_leave = run_done
		& (rcvy_q == `CEF_RCVY_COUNT - 8'h01);

	// next state of the bus-off machine and its counters
	always @* begin
		bus_off_d = bus_off_q;
		run_d     = run_q;
		rcvy_d    = rcvy_q;
		if (bus_off_enter) begin
			bus_off_d = 1'b1;
			run_d     = 4'h0;
			rcvy_d    = 8'h00;
		end else if (bus_off_q) begin
			if (bit_tick_in) begin
				if (!bus_rx_in) begin
					run_d = 4'h0; // dominant bit breaks the run
				end else if (run_done) begin
					run_d  = 4'h0;
					rcvy_d = rcvy_q + 8'h01;
				end else begin
					run_d = run_q + 4'h1;
				end
			end
			if (bus_off_leave) begin
				bus_off_d = 1'b0; // back to error-active
				rcvy_d    = 8'h00;
			end
		end
	end

	// bus-off registers and one-cycle recovery pulse
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			bus_off_q   <= 1'b0;
			run_q       <= 4'h0;
			rcvy_q      <= 8'h00;
			rcvy_done_q <= 1'b0;
		end else begin
			bus_off_q   <= bus_off_d;
			run_q       <= run_d;
			rcvy_q      <= rcvy_d;
			rcvy_done_q <= bus_off_leave;
		end
	end

	// ----------------------------------------------------------------
	// error event flags
	// ----------------------------------------------------------------

	// one set term per flag, held apart from the others; the bus-off flag takes entry or return
	assign set_vec[`CEF_OVL_BIT-`CEF_FLAG_LO] = overload_sent_in;
	assign set_vec[`CEF_BOF_BIT-`CEF_FLAG_LO] =
		bus_off_enter | bus_off_leave;
	assign set_vec[`CEF_EPS_BIT-`CEF_FLAG_LO] = passive_now & ~passive_q;
	assign set_vec[`CEF_RXW_BIT-`CEF_FLAG_LO] = warn_now & ~warn_q;

	// write to the flag register with a one in the bit clears it
	assign flags_wr = wr_strobe_in & (addr_in == `CEF_REG_FLAGS);
	assign clr_vec  = {4{flags_wr}} & wr_data_in[7:`CEF_FLAG_LO];

	// four independent sticky flags
	genvar fi;
	generate
		for (fi = 0; fi < 4; fi = fi + 1) begin : g_flag
			cef_flag_bit u_flag (
				.clk_in     (clk_in),
				.sys_rst_in (sys_rst_in),
				.set_in     (set_vec[fi]),
				.clr_in     (clr_vec[fi]),
				.flag_out   (flag_vec[fi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// mailbox mask and identifier storage
	// ----------------------------------------------------------------

	// masks live in plain storage with no reset; software fills them
	always @(posedge clk_in) begin
		if (wr_strobe_in && is_mb_addr(addr_in)) begin
			mb_mem[mb_index(addr_in)] <= wr_data_in;
		end
	end

	// ----------------------------------------------------------------
	// acceptance filtering
	// ----------------------------------------------------------------

	// one comparator per receive mailbox
	genvar mi;
	generate
		for (mi = 0; mi < NUM_MB; mi = mi + 1) begin : g_mb
			cef_id_match u_match (
				.mask_h1_in   (mb_mem[mi*8 + `CEF_MB_MASK_H1]),
				.mask_l0_in   (mb_mem[mi*8 + `CEF_MB_MASK_L0]),
				.mask_l1_in   (mb_mem[mi*8 + `CEF_MB_MASK_L1]),
				.id_stdh_in   (mb_mem[mi*8 + `CEF_MB_ID_STDH]),
				.id_stdl_in   (mb_mem[mi*8 + `CEF_MB_ID_STDL]),
				.id_extm_in   (mb_mem[mi*8 + `CEF_MB_ID_EXTM]),
				.id_extl_in   (mb_mem[mi*8 + `CEF_MB_ID_EXTL]),
				.rx_ide_in    (rx_ide_in),
				.rx_std_id_in (rx_std_id_in),
				.rx_ext_id_in (rx_ext_id_in),
				.match_out    (match_vec[mi])
			);
		end
	endgenerate

	// result of each received identifier, one cycle later
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			accept_q       <= {NUM_MB{1'b0}};
			accept_valid_q <= 1'b0;
			last_accept_q  <= {NUM_MB{1'b0}};
		end else begin
			accept_valid_q <= rx_id_valid_in;
			if (rx_id_valid_in) begin
				accept_q      <= match_vec;
				last_accept_q <= match_vec;
			end else begin
				accept_q <= {NUM_MB{1'b0}};
			end
		end
	end

	// ----------------------------------------------------------------
	// readable status bytes
	// ----------------------------------------------------------------

	// flag register image; the low nibble always reads zero
	assign flag_byte = {flag_vec, 4'h0};

	// state image: bus-off, passive, warning, bus-off level, run count
	assign state_byte = {
		bus_off_q,
		passive_q,
		warn_q,
		tec_off_q,
		run_q
	};

	// last acceptance result, padded up to a byte
	assign accept_byte = {{(8 - NUM_MB){1'b0}}, last_accept_q};

	// ----------------------------------------------------------------
	// register read path
	// ----------------------------------------------------------------

	// read data for the addressed register; unmapped reads return zero
	always @* begin
		rd_data_d = 8'h00;
		if (rd_strobe_in) begin
			if (is_mb_addr(addr_in)) begin
				rd_data_d = mb_mem[mb_index(addr_in)];
			end else begin
				case (addr_in)
				`CEF_REG_FLAGS: begin
					rd_data_d = flag_byte;
				end
				`CEF_REG_STATE: begin
					rd_data_d = state_byte;
				end
				`CEF_REG_RCVY: begin
					rd_data_d = rcvy_q;
				end
				`CEF_REG_ACCEPT: begin
					rd_data_d = accept_byte;
				end
				default: begin
					rd_data_d = 8'h00;
				end
				endcase
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// every output taken straight from a register
	assign rd_data_out       = rd_data_q;
	assign flags_out         = flag_vec;
	assign bus_off_out       = bus_off_q;
	assign error_passive_out = passive_q;
	assign warning_out       = warn_q;
	assign recovery_done_out = rcvy_done_q;
	assign accept_out        = accept_q;
	assign accept_valid_out  = accept_valid_q;

endmodule

// ===== cef_bus_node.sv
/* cef_bus_node: far-side model of the other bus nodes: error counters,
   overload events, bit ticks and received identifiers.
   Assumes every output changes right after a rising edge of clk_in. */
`timescale 1ns/100ps

module cef_bus_node (
	input  wire        clk_in,
	output reg  [8:0]  tec_out,
	output reg  [7:0]  rec_out,
	output reg         ovl_out,
	output reg         tick_out,
	output reg         rx_out,
	output reg         idv_out,
	output reg         ide_out,
	output reg  [10:0] sid_out,
	output reg  [17:0] eid_out
);
	// ----------------------------------------------------------------
	// bus activity
	// ----------------------------------------------------------------
	// idle bus is recessive
	initial begin
		{tec_out, rec_out, ovl_out, tick_out, idv_out, ide_out} = 21'h0;
		rx_out = 1'b1;
		{sid_out, eid_out} = 29'h0;
	end
	// new counter levels
	task counts(input [8:0] t, input [7:0] r);
		@(posedge clk_in);
		tec_out <= t;
		rec_out <= r;
	endtask
	// overload frame finished
	task ovl;
		@(posedge clk_in);
		ovl_out <= 1'b1;
		@(posedge clk_in);
		ovl_out <= 1'b0;
	endtask
	// one bit time, bus back to recessive after the tick
	task bit_time(input b);
		@(posedge clk_in);
		tick_out <= 1'b1;
		rx_out <= b;
		@(posedge clk_in);
		tick_out <= 1'b0;
		rx_out <= 1'b1;
	endtask
	// received identifier; lines scrambled once the pulse is over
	task frame(input i, input [10:0] s, input [17:0] e);
		@(posedge clk_in);
		idv_out <= 1'b1;
		ide_out <= i;
		sid_out <= s;
		eid_out <= e;
		@(posedge clk_in);
		idv_out <= 1'b0;
		ide_out <= ~i;
		sid_out <= ~s;
		eid_out <= ~e;
	endtask
endmodule

// ===== cef_top_sva.sv
/* cef_top_sva: port-level assertions for cef_top.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps

module cef_top_sva #(
	parameter NUM_MB = 4
) (
	input wire              clk_in,
	input wire              sys_rst_in,
	input wire [5:0]        addr_in,
	input wire [7:0]        wr_data_in,
	input wire              wr_strobe_in,
	input wire              rd_strobe_in,
	input wire [7:0]        rd_data_out,
	input wire [8:0]        tec_in,
	input wire [7:0]        rec_in,
	input wire              overload_sent_in,
	input wire              rx_id_valid_in,
	input wire [3:0]        flags_out,
	input wire              bus_off_out,
	input wire              recovery_done_out,
	input wire [NUM_MB-1:0] accept_out,
	input wire              accept_valid_out
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// write to the flag register
	wire flag_wr;
	assign flag_wr = wr_strobe_in && addr_in == 6'h00;

	AST_OVL_SET: assert property (overload_sent_in |=> flags_out[3])
		else $error("overload flag not set");
	AST_BOF_ENTRY: assert property ($rose(tec_in >= 9'h100) && !bus_off_out |=> bus_off_out && flags_out[2])
		else $error("bus-off entry missed");
	AST_BOF_RETURN: assert property ($fell(bus_off_out) |-> ##[0:1] (recovery_done_out && flags_out[2]))
		else $error("bus-off return not flagged");
	AST_EPS_SET: assert property ($rose(tec_in >= 9'h080 || rec_in >= 8'h80) |=> flags_out[1])
		else $error("passive flag not set");
	AST_RXW_SET: assert property ($rose(rec_in >= 8'h60) |=> flags_out[0])
		else $error("warning flag not set");
	AST_FLAG_KEEP: assert property (!(|($past(flags_out) & ~flags_out & ~({4{$past(flag_wr)}} & $past(wr_data_in[7:4])))))
		else $error("flag dropped without a one written");
	AST_W1C: assert property (flag_wr && wr_data_in[7] && !overload_sent_in |=> !flags_out[3])
		else $error("write one did not clear");
	AST_RD_FLAGS: assert property (rd_strobe_in && addr_in == 6'h00 |=> rd_data_out == {$past(flags_out), 4'h0})
		else $error("flag register read wrong");
	AST_ACC_PULSE: assert property (rx_id_valid_in |=> accept_valid_out ##1 (!accept_valid_out && accept_out == 0))
		else $error("acceptance pulse wrong");

	COV_OVL: cover property (overload_sent_in);
	COV_RCVY: cover property ($fell(bus_off_out));
	COV_HIT: cover property (accept_valid_out && |accept_out);
endmodule

bind cef_top cef_top_sva #(.NUM_MB(NUM_MB)) u_sva (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
	.tec_in(tec_in), .rec_in(rec_in), .overload_sent_in(overload_sent_in),
	.rx_id_valid_in(rx_id_valid_in), .flags_out(flags_out), .bus_off_out(bus_off_out),
	.recovery_done_out(recovery_done_out), .accept_out(accept_out),
	.accept_valid_out(accept_valid_out)
);

// ===== testbench.sv
/* testbench: drives cef_top through its register port and the far-side
   node model; checks flags, bus-off recovery and acceptance filtering.
   Assumes a 20 MHz clock and synchronous active-high reset. */
`timescale 1ns/100ps

module testbench;
	logic        clk_in;
	logic        sys_rst_in;
	logic [5:0]  addr_in;
	logic [7:0]  wr_data_in;
	logic        wr_strobe_in;
	logic        rd_strobe_in;
	wire  [7:0]  rd_data_out;
	wire  [8:0]  tec;
	wire  [7:0]  rec;
	wire         ovl, tick, brx, idv, ide;
	wire         pas, wrn;
	wire  [10:0] sid;
	wire  [17:0] eid;
	wire  [3:0]  flags_out;
	wire  [3:0]  accept_out;
	wire         bus_off_out, accept_valid_out, recovery_done_out;
	int          errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          mbox, x;
	logic [7:0]  mb [4][8];
	logic [7:0]  d;
	logic [10:0] s;
	logic [17:0] e;
	logic        i;
	logic [7:0]  keep [8] = '{8'he0, 8'h00, 8'hff, 8'hff, 8'hff, 8'heb, 8'hff, 8'hff};
	logic [8:0]  t_tab [6] = '{9'h07f, 9'h080, 9'h000, 9'h000, 9'h0ff, 9'h100};
	logic [7:0]  r_tab [6] = '{8'h5f, 8'h00, 8'h80, 8'h60, 8'h00, 8'h00};
	logic [3:0]  f_tab [6] = '{4'h0, 4'h2, 4'h3, 4'h1, 4'h2, 4'h6};

	cef_top #(.NUM_MB(4)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
		.rd_data_out(rd_data_out), .tec_in(tec), .rec_in(rec), .overload_sent_in(ovl),
		.bit_tick_in(tick), .bus_rx_in(brx), .rx_id_valid_in(idv), .rx_ide_in(ide),
		.rx_std_id_in(sid), .rx_ext_id_in(eid), .flags_out(flags_out),
		.bus_off_out(bus_off_out), .error_passive_out(pas), .warning_out(wrn),
		.recovery_done_out(recovery_done_out), .accept_out(accept_out),
		.accept_valid_out(accept_valid_out));
	cef_bus_node node (.clk_in(clk_in), .tec_out(tec), .rec_out(rec), .ovl_out(ovl),
		.tick_out(tick), .rx_out(brx), .idv_out(idv), .ide_out(ide), .sid_out(sid),
		.eid_out(eid));

	// ----------------------------------------------------------------
	// clock, hang guard, helpers
	// ----------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			complete_run();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [5:0] a, input [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_strobe_in <= 1'b1;
		@(posedge clk_in);
		wr_strobe_in <= 1'b0;
	endtask
	task rd(input [5:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_strobe_in <= 1'b1;
		@(posedge clk_in);
		rd_strobe_in <= 1'b0;
		@(posedge clk_in);
		d = rd_data_out;
	endtask
	// expected acceptance vector over all mailboxes
	function automatic logic [3:0] want(input logic id, input logic [10:0] sv,
		input logic [17:0] ev);
		logic [3:0] v;
		for (int j = 0; j < 4; j++)
			v[j] = ((({mb[j][4], mb[j][5][7:5]} ^ sv) & ~{8'h00, mb[j][0][7:5]}) == 0)
				&& mb[j][5][3] == id && (!id || (mb[j][5][1:0] == ev[17:16]
				&& ((({mb[j][6], mb[j][7]} ^ ev[15:0]) & ~{mb[j][2], mb[j][3]}) == 0)));
		return v;
	endfunction
	task complete_run;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{sys_rst_in, addr_in, wr_data_in, wr_strobe_in, rd_strobe_in} = 17'h10000;
		void'($urandom(26));
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(6'h00);
		chk("flag reg", d, 8'h00);
		rd(6'h10);
		chk("unmapped", d, 8'h00);
		$display("reset test done");
		node.ovl();
		@(negedge clk_in);
		chk("ovl set", flags_out, 4'h8);
		wr(6'h00, 8'h70);
		rd(6'h00);
		chk("ovl kept", d, 8'h80);
		fork
			wr(6'h00, 8'h80);
			node.ovl();
		join
		@(negedge clk_in);
		chk("set wins", flags_out, 4'h8);
		wr(6'h00, 8'h80);
		@(negedge clk_in);
		chk("ovl clear", flags_out, 4'h0);
		$display("overload test done");
		for (int k = 0; k < 6; k++) begin
			node.counts(t_tab[k], r_tab[k]);
			repeat (2) @(posedge clk_in);
			@(negedge clk_in);
			chk("event flags", flags_out, f_tab[k]);
			chk("levels", {pas, wrn}, {t_tab[k] >= 9'h080 || r_tab[k] >= 8'h80, r_tab[k] >= 8'h60});
			wr(6'h00, 8'hf0);
			repeat (2) @(negedge clk_in);
			chk("flags cleared", flags_out, 4'h0);
			node.counts(9'h000, 8'h00);
		end
		chk("bus off", bus_off_out, 1'b1);
		// a dominant bit restarts the recessive run
		repeat (10) node.bit_time(1'b1);
		node.bit_time(1'b0);
		rd(6'h01);
		chk("run restart", d, 8'h80);
		repeat (127 * 11) node.bit_time(1'b1);
		@(negedge clk_in);
		chk("still bus off", bus_off_out, 1'b1);
		rd(6'h02);
		chk("occurrences", d, 8'h7f);
		repeat (11) node.bit_time(1'b1);
		@(negedge clk_in);
		chk("rcvy pulse", recovery_done_out, 1'b1);
		@(negedge clk_in);
		chk("recovered", {bus_off_out, recovery_done_out, flags_out}, 6'h04);
		wr(6'h00, 8'hf0);
		$display("error state test done");
		repeat (5) begin
			for (int j = 0; j < 4; j++)
				for (int k = 0; k < 8; k++) begin
					mb[j][k] = 8'($urandom) & keep[k];
					wr(6'(32 + 8 * j + k), mb[j][k]);
					rd(6'(32 + 8 * j + k));
					chk("mailbox reg", d, mb[j][k]);
				end
			repeat (10) begin
				mbox = $urandom % 4;
				x = $urandom % 40;
				s = {mb[mbox][4], mb[mbox][5][7:5]};
				e = {mb[mbox][5][1:0], mb[mbox][6], mb[mbox][7]};
				i = mb[mbox][5][3];
				if (x < 11) s[x] = ~s[x];
				else if (x < 29) e[x - 11] = ~e[x - 11];
				else if (x == 39) i = ~i;
				node.frame(i, s, e);
				@(negedge clk_in);
				chk("accept", {accept_valid_out, accept_out}, {1'b1, want(i, s, e)});
				rd(6'h03);
				chk("last accept", d, {4'h0, want(i, s, e)});
			end
		end
		$display("filter test done");
		complete_run();
	end
endmodule
